//--- design/cawd_pkg.sv
// package: constants and types for the counter array watchdog
// Contract
// [RULE1] low-byte overflow on compare match resets system
// [RULE2] writing one to module 2 flag forces reset
// [RULE3] software configures with watchdog disabled, then enables
// [RULE4] clock and idle selects frozen while enabled
// [RULE5] enable bit or lock bit enables watchdog
// [RULE6] lock keeps watchdog enabled until next reset
// [RULE7] unlocked: clearing enable bit disables watchdog
// [RULE8] reset: enabled, clock/12, low byte, offset zero
// [RULE9] overflow flag set on wrap, software clears
// [RULE10] overflow flag with enable raises interrupt
// [RULE11] run bit stops or starts the counter
// [RULE12] control bits 5:3 read zero, ignore writes
// [RULE13] module flags set on match, request interrupt; code sets no module 2 flag on match while watchdog enabled
// [RULE14] control at 0xd8, also bit addressable
// [RULE15] compare write loads high byte plus offset
// [RULE16] timeout equals 256*offset plus 256-low byte
// [RULE17] enabled: counter forced on, writes ignored
// [RULE18] reset pulse one counter clock, cause recorded
package cawd_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'hd8;
    localparam logic [7:0] ADDR_MODE = 8'hd9;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hf9;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hfa;
    localparam logic [7:0] ADDR_OFFSET = 8'hed;
    localparam logic [7:0] ADDR_COMPARE_HIGH = 8'hfe;
    localparam logic [7:0] ADDR_MOD2_MODE = 8'hdc;
    localparam logic [4:0] CONTROL_BIT_BASE = 5'h1b;
    localparam int BIT_OVERFLOW = 7;
    localparam int BIT_RUN = 6;
    localparam int BIT_MOD2 = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] MOD2_MODE_RESET = 8'h00;
    localparam logic [7:0] LOW_BYTE_MAX = 8'hff;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [2:0] CLK_SEL_DIV12 = 3'h0;
    localparam logic [2:0] CLK_SEL_DIV4 = 3'h1;
    localparam logic [2:0] CLK_SEL_EXT = 3'h2;
    localparam logic [2:0] CLK_SEL_SYS = 3'h4;

    typedef struct packed {
        logic idle_suspend_select;
        logic watchdog_enable_bit;
        logic watchdog_lock_bit;
        logic unused_bit;
        logic [2:0] counter_clock_select;
        logic overflow_int_en;
    } cawd_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cawd_sfr_req_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wdata;
        logic wr;
        logic rd;
    } cawd_bit_req_type;
endpackage

//--- design/cawd_flag.sv
// sticky flag: hardware set wins over software write
`timescale 1ns/100ps
`default_nettype none
module cawd_flag (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hw_set,
    input wire logic sw_wr,
    input wire logic sw_val,
    output logic flag_q
);
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (sw_wr) begin
            flag_d = sw_val;
        end
        if (hw_set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule
`default_nettype wire

//--- design/cawd_top.sv
// counter array with watchdog on module 2 and control register
`timescale 1ns/100ps
`default_nettype none
module cawd_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire cawd_pkg::cawd_sfr_req_type sfr_req,
    input wire cawd_pkg::cawd_bit_req_type bit_req,
    input wire logic ext_tick,
    input wire logic cpu_idle,
    input wire logic [2:0] module_match,
    input wire logic [2:0] module_int_en,
    output logic [7:0] sfr_rdata_q,
    output logic bit_rdata_q,
    output logic irq_q,
    output logic wd_reset_q,
    output logic wd_cause_q
);
    cawd_pkg::cawd_mode_type mode_q, mode_d;
    logic [3:0] div_q, div_d;
    logic [7:0] low_q, low_d, high_q, high_d;
    logic [7:0] offset_q, offset_d, cmp_q, cmp_d, mod2_q, mod2_d;
    logic run_q, run_d;
    logic wd_reset_d, wd_cause_d, irq_d, bit_rdata_d;
    logic [7:0] sfr_rdata_d;
    logic [7:0] ctrl_view;
    logic [7:0] ctrl_wval;
    logic [7:0] ctrl_wmask;
    logic [3:0] flags_q;
    logic [3:0] flags_set;
    logic wd_en, tick, counting, low_wrap, full_wrap, force_rst, timeout;
    logic wr_sfr_ctrl, bit_hit;
    logic [2:0] bit_idx;

    assign wd_en = mode_q.watchdog_enable_bit | mode_q.watchdog_lock_bit; // [RULE5] [RULE6] [RULE7]
    assign wr_sfr_ctrl = sfr_req.wr && sfr_req.addr == cawd_pkg::ADDR_CONTROL; // [RULE14]
    assign bit_hit = bit_req.addr[7:3] == cawd_pkg::CONTROL_BIT_BASE; // [RULE14]
    assign bit_idx = bit_req.addr[2:0];

    // prescaler tick from selected source
    always_comb begin
        div_d = div_q + 4'h1;
        tick = 1'b0;
        case (mode_q.counter_clock_select)
            cawd_pkg::CLK_SEL_DIV4: begin
                if (div_q >= cawd_pkg::DIV4_LAST) begin
                    div_d = 4'h0;
                    tick = 1'b1;
                end
            end
            cawd_pkg::CLK_SEL_EXT: begin
                div_d = 4'h0;
                tick = ext_tick;
            end
            cawd_pkg::CLK_SEL_SYS: begin
                div_d = 4'h0;
                tick = 1'b1;
            end
            default: begin
                if (div_q >= cawd_pkg::DIV12_LAST) begin // [RULE8]
                    div_d = 4'h0;
                    tick = 1'b1;
                end
            end
        endcase
    end

    assign counting = tick && (run_q || wd_en) // [RULE11] [RULE17]
        && !(mode_q.idle_suspend_select && cpu_idle);
    assign low_wrap = counting && low_q == cawd_pkg::LOW_BYTE_MAX;
    assign full_wrap = low_wrap && {high_q, low_q} == cawd_pkg::COUNT_MAX; // [RULE9]
    assign timeout = wd_en && low_wrap && cmp_q == high_q; // [RULE1] [RULE16]

    // control write value and mask, bits 5:3 never written
    always_comb begin
        ctrl_wval = 8'h00;
        ctrl_wmask = 8'h00;
        if (wr_sfr_ctrl) begin
            ctrl_wval = sfr_req.wdata;
            ctrl_wmask = 8'hc7; // [RULE12]
        end else if (bit_req.wr && bit_hit) begin
            ctrl_wval[bit_idx] = bit_req.wdata;
            ctrl_wmask[bit_idx] = 1'b1;
        end
        ctrl_wmask[5:3] = 3'h0; // [RULE12]
    end

    assign force_rst = wd_en && ctrl_wmask[cawd_pkg::BIT_MOD2] // [RULE2]
        && ctrl_wval[cawd_pkg::BIT_MOD2];
    assign flags_set = {full_wrap, module_match[2] && !wd_en, module_match[1:0]}; // [RULE13]

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            localparam int POS = (gi == 3) ? cawd_pkg::BIT_OVERFLOW : gi;
            cawd_flag u_flag (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .hw_set(flags_set[gi]),
                .sw_wr(ctrl_wmask[POS]),
                .sw_val(ctrl_wval[POS]),
                .flag_q(flags_q[gi])
            ); // [RULE9] [RULE13]
        end
    endgenerate

    assign ctrl_view = {flags_q[3], run_q, 3'b000, flags_q[2:0]}; // [RULE12]

    // register updates
    always_comb begin
        mode_d = mode_q;
        low_d = low_q;
        high_d = high_q;
        offset_d = offset_q;
        cmp_d = cmp_q;
        mod2_d = mod2_q;
        run_d = run_q;
        if (ctrl_wmask[cawd_pkg::BIT_RUN]) begin
            run_d = ctrl_wval[cawd_pkg::BIT_RUN]; // [RULE11]
        end
        if (counting) begin
            {high_d, low_d} = {high_q, low_q} + 16'h0001;
        end
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                cawd_pkg::ADDR_MODE: begin
                    mode_d.overflow_int_en = sfr_req.wdata[0];
                    mode_d.watchdog_enable_bit = sfr_req.wdata[6]; // [RULE7]
                    if (sfr_req.wdata[5]) begin
                        mode_d.watchdog_lock_bit = 1'b1; // [RULE6]
                    end
                    if (!wd_en) begin
                        mode_d.idle_suspend_select = sfr_req.wdata[7]; // [RULE4]
                        mode_d.counter_clock_select = sfr_req.wdata[3:1]; // [RULE4]
                    end
                end
                cawd_pkg::ADDR_COUNT_LOW: begin
                    if (!wd_en) begin
                        low_d = sfr_req.wdata; // [RULE17]
                    end
                end
                cawd_pkg::ADDR_COUNT_HIGH: begin
                    if (!wd_en) begin
                        high_d = sfr_req.wdata; // [RULE17]
                    end
                end
                cawd_pkg::ADDR_OFFSET: begin
                    offset_d = sfr_req.wdata;
                end
                cawd_pkg::ADDR_COMPARE_HIGH: begin
                    cmp_d = wd_en ? high_q + offset_q : sfr_req.wdata; // [RULE15]
                end
                cawd_pkg::ADDR_MOD2_MODE: begin
                    if (!wd_en) begin
                        mod2_d = sfr_req.wdata; // [RULE17]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // outputs: reads, interrupt, reset pulse and cause
    always_comb begin
        sfr_rdata_d = sfr_rdata_q;
        bit_rdata_d = bit_rdata_q;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                cawd_pkg::ADDR_CONTROL: sfr_rdata_d = ctrl_view; // [RULE14]
                cawd_pkg::ADDR_MODE: sfr_rdata_d = {mode_q[7:5], 1'b0, mode_q[3:0]};
                cawd_pkg::ADDR_COUNT_LOW: sfr_rdata_d = low_q;
                cawd_pkg::ADDR_COUNT_HIGH: sfr_rdata_d = high_q;
                cawd_pkg::ADDR_OFFSET: sfr_rdata_d = offset_q;
                cawd_pkg::ADDR_COMPARE_HIGH: sfr_rdata_d = cmp_q;
                cawd_pkg::ADDR_MOD2_MODE: sfr_rdata_d = mod2_q;
                default: sfr_rdata_d = 8'h00;
            endcase
        end
        if (bit_req.rd) begin
            bit_rdata_d = bit_hit ? ctrl_view[bit_idx] : 1'b0; // [RULE14]
        end
        irq_d = (flags_q[3] && mode_q.overflow_int_en) // [RULE10]
            || |(flags_q[2:0] & module_int_en); // [RULE13]
        wd_reset_d = wd_reset_q;
        if (tick) begin
            wd_reset_d = 1'b0; // [RULE18]
        end
        if (timeout || force_rst) begin
            wd_reset_d = 1'b1; // [RULE1] [RULE2] [RULE18]
        end
        wd_cause_d = wd_cause_q;
        if (timeout || force_rst) begin
            wd_cause_d = 1'b1; // [RULE18]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_q <= cawd_pkg::MODE_RESET; // [RULE8]
            div_q <= 4'h0;
            low_q <= cawd_pkg::COUNT_RESET; // [RULE8]
            high_q <= cawd_pkg::COUNT_RESET;
            offset_q <= cawd_pkg::OFFSET_RESET; // [RULE8]
            cmp_q <= cawd_pkg::COMPARE_RESET;
            mod2_q <= cawd_pkg::MOD2_MODE_RESET;
            run_q <= cawd_pkg::CONTROL_RESET[cawd_pkg::BIT_RUN];
            sfr_rdata_q <= 8'h00;
            bit_rdata_q <= 1'b0;
            irq_q <= 1'b0;
            wd_reset_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            div_q <= div_d;
            low_q <= low_d;
            high_q <= high_d;
            offset_q <= offset_d;
            cmp_q <= cmp_d;
            mod2_q <= mod2_d;
            run_q <= run_d;
            sfr_rdata_q <= sfr_rdata_d;
            bit_rdata_q <= bit_rdata_d;
            irq_q <= irq_d;
            wd_reset_q <= wd_reset_d;
        end
    end

    // cause survives system reset, cleared by power-on only
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            wd_cause_q <= 1'b0;
        end else begin
            wd_cause_q <= wd_cause_d;
        end
    end
endmodule
`default_nettype wire

//--- dv/cawd_props.sv
// checker: port-level properties of the counter array watchdog
`timescale 1ns/100ps
`default_nettype none
module cawd_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire cawd_pkg::cawd_sfr_req_type sfr_req,
    input wire cawd_pkg::cawd_bit_req_type bit_req,
    input wire logic ext_tick,
    input wire logic cpu_idle,
    input wire logic [2:0] module_match,
    input wire logic [2:0] module_int_en,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic bit_rdata_q,
    input wire logic irq_q,
    input wire logic wd_reset_q,
    input wire logic wd_cause_q
);
    logic en_q, en_d, lock_q, lock_d, idl_q, idl_d;
    logic [2:0] cps_q, cps_d;
    default clocking @(posedge ref_clk); endclocking
    // mirror of enable, lock and frozen selects
    always_comb begin
        {en_d, lock_d, idl_d, cps_d} = {en_q, lock_q, idl_q, cps_q};
        if (sfr_req.wr && sfr_req.addr == 8'hd9) begin
            lock_d = lock_q | sfr_req.wdata[5];
            en_d = sfr_req.wdata[6] | lock_d;
            if (!en_q) begin
                {idl_d, cps_d} = {sfr_req.wdata[7], sfr_req.wdata[3:1]};
            end
        end
        if (sys_rst) begin
            {en_d, lock_d, idl_d, cps_d} = 6'h20;
        end
    end
    always_ff @(posedge ref_clk) begin
        {en_q, lock_q, idl_q, cps_q} <= {en_d, lock_d, idl_d, cps_d};
    end
    sequence force_wr_s;
        en_q && ((sfr_req.wr && sfr_req.addr == 8'hd8 && sfr_req.wdata[2])
            || (bit_req.wr && bit_req.addr == 8'hda && bit_req.wdata
            && !(sfr_req.wr && sfr_req.addr == 8'hd8)));
    endsequence
    sequence mode_rd_s;
        sfr_req.rd && sfr_req.addr == 8'hd9;
    endsequence
    rst_outs_a: assert property (sys_rst |=> !wd_reset_q && !irq_q && !bit_rdata_q
        && sfr_rdata_q == 8'h00) else $error("outputs not cleared by reset");
    cause_set_a: assert property (disable iff (sys_rst) $rose(wd_reset_q) |-> ##[0:1] wd_cause_q)
        else $error("reset cause not recorded");
    cause_keep_a: assert property (disable iff (por_rst) wd_cause_q |=> wd_cause_q)
        else $error("reset cause lost");
    ctl_zero_a: assert property (disable iff (sys_rst) sfr_req.rd && sfr_req.addr == 8'hd8
        |=> sfr_rdata_q[5:3] == 3'h0) else $error("unused control bits not zero");
    bit_zero_a: assert property (disable iff (sys_rst) bit_req.rd
        && bit_req.addr inside {8'hdb, 8'hdc, 8'hdd} |=> !bit_rdata_q) else $error("unused bit set");
    force_rst_a: assert property (disable iff (sys_rst) force_wr_s |=> wd_reset_q)
        else $error("forced reset missing");
    read_hold_a: assert property (disable iff (sys_rst) !sfr_req.rd |=> $stable(sfr_rdata_q))
        else $error("read data moved");
    mode_frz_a: assert property (disable iff (sys_rst) mode_rd_s |=> sfr_rdata_q[7] == idl_q
        && sfr_rdata_q[5:1] == {lock_q, 1'b0, cps_q}) else $error("mode fields wrong");
endmodule
bind cawd_top cawd_props i_props (.ref_clk, .sys_rst, .por_rst, .sfr_req, .bit_req, .ext_tick,
    .cpu_idle, .module_match, .module_int_en, .sfr_rdata_q, .bit_rdata_q, .irq_q, .wd_reset_q,
    .wd_cause_q);
`default_nettype wire

//--- dv/test_cawd_top.sv
// testbench: register-level tests of the counter array watchdog
`timescale 1ns/100ps
`default_nettype none
module test_cawd_top;
    logic ref_clk = 1'b0, sys_rst = 1'b1, por_rst = 1'b1, idle = 1'b0, ext = 1'b0;
    logic [2:0] match = 3'h0, int_en = 3'h0;
    cawd_pkg::cawd_sfr_req_type sreq = '0;
    cawd_pkg::cawd_bit_req_type breq = '0;
    logic [7:0] rdata;
    logic bdata, irq, wdr, cause;
    int err_total = 0, tests_run = 0, n;
    always #10 ref_clk = ~ref_clk;
    cawd_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst), .sfr_req(sreq),
        .bit_req(breq), .ext_tick(ext), .cpu_idle(idle), .module_match(match),
        .module_int_en(int_en), .sfr_rdata_q(rdata), .bit_rdata_q(bdata), .irq_q(irq),
        .wd_reset_q(wdr), .wd_cause_q(cause));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sreq = '{a, d, 1'b1, 1'b0};
        tick(1);
        sreq.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        tick(1);
        sreq = '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        sreq.rd = 1'b0;
        chk(nm, rdata, e);
    endtask
    task automatic bwr(input logic [7:0] a, input logic d);
        tick(1);
        breq = '{a, d, 1'b1, 1'b0};
        tick(1);
        breq.wr = 1'b0;
    endtask
    task automatic brd(input logic [7:0] a, input logic e, input string nm);
        tick(1);
        breq = '{a, 1'b0, 1'b0, 1'b1};
        tick(1);
        breq.rd = 1'b0;
        chk(nm, {7'h00, bdata}, {7'h00, e});
    endtask
    task automatic wait_wd(input int lim);
        n = 0;
        while (wdr !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic do_rst(input logic p);
        tick(1);
        {sys_rst, por_rst} = {1'b1, p};
        tick(10);
        {sys_rst, por_rst} = 2'b00;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #600000;
        err_total++;
        print_verdict();
    end
    initial begin
        tick(10);
        {sys_rst, por_rst} = 2'b00;
        wait_wd(3200);
        chk("timeout", 8'(n >= 3060 && n <= 3090), 8'h01);
        tick(6);
        chk("pulse", wdr, 1'b1);
        tick(8);
        chk("pulse end", {cause, wdr}, 8'h02);
        do_rst(1'b0);
        chk("cause", cause, 1'b1);
        rd(8'hd8, 8'h00, "control");
        rd(8'hd9, 8'h40, "mode");
        rd(8'hed, 8'h00, "offset");
        $display("test reset done");
        wr(8'hd9, 8'h00);
        wr(8'hd8, 8'h04);
        tick(2);
        chk("no forced reset", wdr, 1'b0);
        wr(8'hd9, 8'h09);
        rd(8'hd9, 8'h09, "mode sel");
        wr(8'hd8, 8'h38);
        rd(8'hd8, 8'h00, "unused");
        wr(8'hfa, 8'hff);
        wr(8'hf9, 8'hf0);
        bwr(8'hde, 1'b1);
        tick(30);
        rd(8'hd8, 8'hc0, "overflow");
        chk("ovf irq", irq, 1'b1);
        wr(8'hd8, 8'h00);
        tick(1);
        chk("irq clear", irq, 1'b0);
        wr(8'hf9, 8'h00);
        tick(5);
        rd(8'hf9, 8'h00, "stopped");
        int_en = 3'h1;
        match = 3'h7;
        tick(1);
        match = 3'h0;
        tick(2);
        rd(8'hd8, 8'h07, "flags");
        chk("flag irq", irq, 1'b1);
        brd(8'hd9, 1'b1, "flag bit");
        brd(8'hdc, 1'b0, "unused bit");
        $display("test counter done");
        wr(8'hed, 8'h02);
        wr(8'hd9, 8'h48);
        wr(8'hd9, 8'h4e);
        rd(8'hd9, 8'h48, "frozen");
        wr(8'hfa, 8'h80);
        rd(8'hfa, 8'h00, "count high");
        wr(8'hfe, 8'h55);
        rd(8'hfe, 8'h02, "compare");
        tick(700);
        chk("early", wdr, 1'b0);
        wait_wd(100);
        chk("update timeout", 8'(n >= 30 && n <= 80), 8'h01);
        $display("test update done");
        do_rst(1'b0);
        wr(8'hd9, 8'h00);
        wr(8'hd9, 8'h84);
        wr(8'hf9, 8'h00);
        bwr(8'hde, 1'b1);
        ext = 1'b1;
        tick(3);
        ext = 1'b0;
        rd(8'hf9, 8'h03, "ext count");
        idle = 1'b1;
        ext = 1'b1;
        tick(3);
        ext = 1'b0;
        idle = 1'b0;
        rd(8'hf9, 8'h03, "idle hold");
        $display("test source done");
        wr(8'hd9, 8'h60);
        wr(8'hd9, 8'h00);
        rd(8'hd9, 8'h20, "locked");
        bwr(8'hda, 1'b1);
        wait_wd(3);
        chk("forced", 8'(n < 3), 8'h01);
        do_rst(1'b1);
        chk("cause cleared", cause, 1'b0);
        $display("test lock done");
        print_verdict();
    end
endmodule
`default_nettype wire
